// *** core/mplm_pkg.sv ***
// Purpose: Shared constants and types for the multi-lane SPI host pad lane mapping
// Assumes: 32-bit AXI4-Lite register bus, 19 pads per instance
// Notes:   Pad index i matches bit i of the output enable mask
package mplm_pkg;

   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int PADS = 19;
   localparam int DATA_LANES = 16;
   localparam int ADDR_W = 12;
   localparam int CW_W = 26;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [11:0] OFF_DEVCFG = 12'h000;
   localparam logic [11:0] OFF_PADOE = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [31:0] DEVCFG_RST = 32'h0000_0000;
   localparam logic [31:0] PADOE_RST = 32'h0000_0000;
   localparam logic [31:0] DEVCFG_WMASK = 32'h0000_031F;
   localparam logic [31:0] PADOE_WMASK = 32'h0007_FFFF;
   localparam int CFG_SEPIO_BIT = 8;
   localparam int CFG_RELOC_BIT = 9;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LEGAL_BIT = 1;
   localparam int STAT_HEX_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************************
   // Device mode codes, chip enable 0 / 1
   // ***************************************************************
   localparam logic [4:0] MODE_SER0 = 5'h01;
   localparam logic [4:0] MODE_SER1 = 5'h02;
   localparam logic [4:0] MODE_DUAL0 = 5'h05;
   localparam logic [4:0] MODE_DUAL1 = 5'h06;
   localparam logic [4:0] MODE_QUAD0 = 5'h09;
   localparam logic [4:0] MODE_QUAD1 = 5'h0A;
   localparam logic [4:0] MODE_OCT0 = 5'h0D;
   localparam logic [4:0] MODE_OCT1 = 5'h0E;
   localparam logic [4:0] MODE_HEX0 = 5'h11;
   localparam logic [4:0] MODE_HEX1 = 5'h12;

   // ***************************************************************
   // Pad positions and lane groups
   // ***************************************************************
   localparam int PAD_RX_SEP = 1;
   localparam int PAD_LANE4 = 4;
   localparam int PAD_CLK = 8;
   localparam logic [18:0] LANES_SER_OUT = 19'h00001;
   localparam logic [18:0] LANES_DUAL = 19'h00003;
   localparam logic [18:0] LANES_QUAD = 19'h0000F;
   localparam logic [18:0] LANES_OCT = 19'h002FF;
   localparam logic [18:0] LANES_HEX = 19'h7FEFF;
   localparam logic [18:0] LANES_UPPER = 19'h7FC00;

   typedef enum {W_NONE, W_SERIAL, W_DUAL, W_QUAD, W_OCTAL, W_HEX} mplm_width_t;

endpackage

// *** core/mplm_sync.sv ***
// Purpose: Two flip-flop level synchroniser
// Assumes: Each bit is an independent level
// Notes:   The first stage is read only by the second stage
`timescale 1ns/10ps
module mplm_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input wire logic clk,
   // Level in and synchronised level out
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   // Next values of both stages
   always_comb
   begin
      meta_d = asyncIn;
      sync_d = meta_q;
   end

   // Stage registers
   always_ff @(posedge clk)
   begin
      meta_q <= meta_d;
      syncOut <= sync_d;
   end
endmodule

// *** core/mplm_pad_lane_map.sv ***
// Purpose: Pad lane mapping, output enables, clock relocation and receive redirect
// Assumes: Transfer engine runs on linkClk; registers reached over AXI4-Lite on clk
// Notes:   Configuration crosses to linkClk by a toggle handshake on a held word
// Behaviour
// - Each instance supports serial, dual, quad and octal widths, each with a variant per chip enable.
// - Serial width drives lane 0 as output only, takes lane 1 as input only, and the clock pad is an output unless relocation is set.
// - Dual width uses lanes 0 and 1 bidirectionally and leaves higher lanes unused.
// - Quad width uses lanes 0 to 3 bidirectionally and leaves higher lanes and the strobe unused.
// - Octal width uses lanes 0 to 7 and the mask/strobe line bidirectionally.
// - Only instance 0 has hex width, with sixteen lanes and two strobes, the second for the upper byte.
// - In serial, dual or quad width with relocation set, the clock leaves on lane 4 instead of the clock pad.
// - With separate-I/O set, pad lane 1 feeds receive input 0.
// - Mode codes are serial 1/2, dual 5/6, quad 9/0xA, octal 0xD/0xE, hex 0x11/0x12 for chip enable 0/1.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module mplm_pad_lane_map
   import mplm_pkg::*;
#(
   parameter int INSTANCE = 0
) (
   // Register clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Transfer engine on the link clock
   input wire logic linkClk,
   input wire logic linkSclk,
   input wire logic linkTx,
   input wire logic linkCe,
   input wire logic [DATA_LANES-1:0] txData,
   input wire logic [1:0] txStrobe,
   output logic [DATA_LANES-1:0] rxData,
   output logic [1:0] rxStrobe,
   // Pads
   input wire logic [PADS-1:0] padIn,
   output logic [PADS-1:0] padOut,
   output logic [PADS-1:0] padOe,
   output logic chipEnableZeroN,
   output logic chipEnableOneN
);
   localparam bit HAS_HEX = (INSTANCE == 0);

   // ***************************************************************
   // Elaboration check
   // ***************************************************************
   if (INSTANCE < 0 || INSTANCE > 2)
   begin : g_badInst
      $error("INSTANCE must be 0, 1 or 2");
   end

   // Width from a mode code; hex only where supported
   function automatic mplm_width_t widthOf(input logic [4:0] code);
      mplm_width_t w;
      w = W_NONE;
      case (code)
         MODE_SER0, MODE_SER1: w = W_SERIAL;
         MODE_DUAL0, MODE_DUAL1: w = W_DUAL;
         MODE_QUAD0, MODE_QUAD1: w = W_QUAD;
         MODE_OCT0, MODE_OCT1: w = W_OCTAL;
         MODE_HEX0, MODE_HEX1: w = HAS_HEX ? W_HEX : W_NONE;
         default: w = W_NONE;
      endcase
      return w;
   endfunction

   // Chip enable one variant
   function automatic logic chipOneOf(input logic [4:0] code);
      return (code == MODE_SER1) || (code == MODE_DUAL1) || (code == MODE_QUAD1) ||
             (code == MODE_OCT1) || (code == MODE_HEX1);
   endfunction

   // ***************************************************************
   // AXI4-Lite slave and registers
   // ***************************************************************
   logic awReady_d, wReady_d, bValid_d, arReady_d, rValid_d;
   logic [1:0] bResp_d, rResp_d;
   logic [31:0] rData_d;
   logic [ADDR_W-1:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic [31:0] devCfg_q, devCfg_d, padOeReg_q, padOeReg_d;
   logic [31:0] byteMask;
   logic [ADDR_W-1:0] wrWord, rdWord;
   logic doWrite, cfgWritten, busy;
   logic [31:0] statusWord;

   // Byte lane mask and aligned addresses
   always_comb
   begin
      byteMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
      wrWord = {awAddr_q[ADDR_W-1:2], 2'h0};
      rdWord = {s_axi_araddr[ADDR_W-1:2], 2'h0};
      doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
      statusWord = 32'h0000_0000;
      statusWord[STAT_BUSY_BIT] = busy;
      statusWord[STAT_LEGAL_BIT] = (widthOf(devCfg_q[4:0]) != W_NONE);
      statusWord[STAT_HEX_BIT] = HAS_HEX;
   end

   // Next bus and register state
   always_comb
   begin
      awReady_d = s_axi_awready;
      wReady_d = s_axi_wready;
      bValid_d = s_axi_bvalid;
      bResp_d = s_axi_bresp;
      arReady_d = s_axi_arready;
      rValid_d = s_axi_rvalid;
      rResp_d = s_axi_rresp;
      rData_d = s_axi_rdata;
      awAddr_d = awAddr_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      devCfg_d = devCfg_q;
      padOeReg_d = padOeReg_q;
      cfgWritten = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awAddr_d = s_axi_awaddr;
         awReady_d = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
         wReady_d = 1'b0;
      end
      if (doWrite)
      begin
         bValid_d = 1'b1;
         bResp_d = RESP_OKAY;
         if (wrWord == OFF_DEVCFG)
         begin
            devCfg_d = ((devCfg_q & ~byteMask) | (wData_q & byteMask)) & DEVCFG_WMASK;
            cfgWritten = 1'b1;
         end
         else if (wrWord == OFF_PADOE)
         begin
            padOeReg_d = ((padOeReg_q & ~byteMask) | (wData_q & byteMask)) & PADOE_WMASK;
            cfgWritten = 1'b1;
         end
         else if (wrWord != OFF_STATUS)
         begin
            bResp_d = RESP_SLVERR;
         end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         bValid_d = 1'b0;
         awReady_d = 1'b1;
         wReady_d = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         arReady_d = 1'b0;
         rValid_d = 1'b1;
         rResp_d = RESP_OKAY;
         case (rdWord)
            OFF_DEVCFG: rData_d = devCfg_q;
            OFF_PADOE: rData_d = padOeReg_q;
            OFF_STATUS: rData_d = statusWord;
            default:
            begin
               rData_d = 32'h0000_0000;
               rResp_d = RESP_SLVERR;
            end
         endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         rValid_d = 1'b0;
         arReady_d = 1'b1;
      end
   end

   // Bus and register flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         awAddr_q <= 12'h000;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         devCfg_q <= DEVCFG_RST;
         padOeReg_q <= PADOE_RST;
      end
      else
      begin
         s_axi_awready <= awReady_d;
         s_axi_wready <= wReady_d;
         s_axi_bvalid <= bValid_d;
         s_axi_bresp <= bResp_d;
         s_axi_arready <= arReady_d;
         s_axi_rvalid <= rValid_d;
         s_axi_rresp <= rResp_d;
         s_axi_rdata <= rData_d;
         awAddr_q <= awAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         devCfg_q <= devCfg_d;
         padOeReg_q <= padOeReg_d;
      end
   end

   // ***************************************************************
   // Configuration handshake, register side
   // ***************************************************************
   logic dirty_q, dirty_d, reqTog_q, reqTog_d, ackSync, send;
   logic [CW_W-1:0] cfgHeld_q, cfgHeld_d;

   // Send the packed word when idle; a write during a send stays pending
   always_comb
   begin
      busy = (reqTog_q != ackSync);
      send = dirty_q && !busy;
      dirty_d = (dirty_q && !send) || cfgWritten;
      reqTog_d = send ? !reqTog_q : reqTog_q;
      cfgHeld_d = send ? {padOeReg_q[PADS-1:0], devCfg_q[CFG_RELOC_BIT], devCfg_q[CFG_SEPIO_BIT], devCfg_q[4:0]}
                       : cfgHeld_q;
   end

   // Handshake flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dirty_q <= 1'b1;
         reqTog_q <= 1'b0;
         cfgHeld_q <= '0;
      end
      else
      begin
         dirty_q <= dirty_d;
         reqTog_q <= reqTog_d;
         cfgHeld_q <= cfgHeld_d;
      end
   end

   // ***************************************************************
   // Link clock domain
   // ***************************************************************
   logic linkRst, reqSync, reqSeen_q, reqSeen_d;
   logic [CW_W-1:0] cfgLink_q, cfgLink_d;
   logic [PADS-1:0] padInS;

   mplm_sync #(.WIDTH(1)) u_rstSync (.clk(linkClk), .asyncIn(rst), .syncOut(linkRst));
   mplm_sync #(.WIDTH(1)) u_reqSync (.clk(linkClk), .asyncIn(reqTog_q), .syncOut(reqSync));
   mplm_sync #(.WIDTH(1)) u_ackSync (.clk(clk), .asyncIn(reqSeen_q), .syncOut(ackSync));
   mplm_sync #(.WIDTH(PADS)) u_padSync (.clk(linkClk), .asyncIn(padIn), .syncOut(padInS));

   // Decoded link-side configuration
   logic [4:0] lMode;
   logic lSepio, lReloc, lChipOne, lLegal, relocEff;
   logic [PADS-1:0] lMask, bidirLanes, outLanes, padData;
   mplm_width_t lWidth;
   logic [PADS-1:0] padOut_d, padOe_d;
   logic [DATA_LANES-1:0] rxData_d;
   logic [1:0] rxStrobe_d;
   logic ceZeroN_d, ceOneN_d;

   // Lane roles per width and pad drive
   always_comb
   begin
      reqSeen_d = reqSync;
      cfgLink_d = (reqSync != reqSeen_q) ? cfgHeld_q : cfgLink_q;
      lMode = cfgLink_q[4:0];
      lSepio = cfgLink_q[5];
      lReloc = cfgLink_q[6];
      lMask = cfgLink_q[CW_W-1:7];
      lWidth = widthOf(lMode);
      lChipOne = chipOneOf(lMode);
      lLegal = (lWidth != W_NONE);
      bidirLanes = '0;
      outLanes = '0;
      case (lWidth)
         W_SERIAL: outLanes = LANES_SER_OUT;
         W_DUAL: bidirLanes = LANES_DUAL;
         W_QUAD: bidirLanes = LANES_QUAD;
         W_OCTAL: bidirLanes = LANES_OCT;
         W_HEX: bidirLanes = LANES_HEX;
         default: bidirLanes = '0;
      endcase
      relocEff = lReloc && (lWidth == W_SERIAL || lWidth == W_DUAL || lWidth == W_QUAD);
      padData = {txStrobe[1], txData[15:8], txStrobe[0], linkSclk, txData[7:0]};
      padOut_d = padData;
      padOe_d = lMask & ((bidirLanes & {PADS{linkTx}}) | outLanes);
      padOe_d[PAD_CLK] = lMask[PAD_CLK] && lLegal && !relocEff;
      if (relocEff)
      begin
         padOut_d[PAD_LANE4] = linkSclk;
         padOe_d[PAD_LANE4] = lMask[PAD_LANE4];
      end
      rxData_d = {padInS[17:10], padInS[7:0]};
      if (lSepio)
      begin
         rxData_d[0] = padInS[PAD_RX_SEP];
      end
      rxStrobe_d = {padInS[18], padInS[9]};
      ceZeroN_d = !(lLegal && linkCe && !lChipOne);
      ceOneN_d = !(lLegal && linkCe && lChipOne);
   end

   // Link-side flops
   always_ff @(posedge linkClk)
   begin
      if (linkRst)
      begin
         reqSeen_q <= 1'b0;
         cfgLink_q <= '0;
         padOut <= '0;
         padOe <= '0;
         rxData <= '0;
         rxStrobe <= 2'h0;
         chipEnableZeroN <= 1'b1;
         chipEnableOneN <= 1'b1;
      end
      else
      begin
         reqSeen_q <= reqSeen_d;
         cfgLink_q <= cfgLink_d;
         padOut <= padOut_d;
         padOe <= padOe_d;
         rxData <= rxData_d;
         rxStrobe <= rxStrobe_d;
         chipEnableZeroN <= ceZeroN_d;
         chipEnableOneN <= ceOneN_d;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_serialLaneOne;
      @(posedge linkClk) disable iff (linkRst) (lWidth == W_SERIAL) |=> !padOe[PAD_RX_SEP] && !padOe[2];
   endproperty
   a_serialLaneOne: assert property (p_serialLaneOne) else $error("serial lane 1 driven");

   property p_dualUpper;
      @(posedge linkClk) disable iff (linkRst) (lWidth == W_DUAL) && !lReloc |=> (padOe & ~LANES_DUAL) == (padOe & 19'h00100);
   endproperty
   a_dualUpper: assert property (p_dualUpper) else $error("dual upper lane driven");

   property p_quadUpper;
      @(posedge linkClk) disable iff (linkRst) (lWidth == W_QUAD) && !lReloc |=> (padOe & 19'h7FEF0) == 19'h00000;
   endproperty
   a_quadUpper: assert property (p_quadUpper) else $error("quad upper lane or strobe driven");

   property p_octStrobe;
      @(posedge linkClk) disable iff (linkRst) (lWidth == W_OCTAL) && linkTx && lMask[9] |=> padOe[9] ##0 padOut[9] == $past(txStrobe[0]);
   endproperty
   a_octStrobe: assert property (p_octStrobe) else $error("octal strobe not driven");

   property p_noHexElsewhere;
      @(posedge linkClk) disable iff (linkRst) (lWidth != W_HEX) |=> (padOe & LANES_UPPER) == 19'h00000;
   endproperty
   a_noHexElsewhere: assert property (p_noHexElsewhere) else $error("upper lanes outside hex width");

   property p_clockRelocate;
      @(posedge linkClk) disable iff (linkRst) relocEff && lMask[PAD_LANE4] |=> padOe[PAD_LANE4] && !padOe[PAD_CLK] && padOut[PAD_LANE4] == $past(linkSclk);
   endproperty
   a_clockRelocate: assert property (p_clockRelocate) else $error("clock not on lane 4");

   property p_sepRedirect;
      @(posedge linkClk) disable iff (linkRst) lSepio |=> rxData[0] == $past(padInS[PAD_RX_SEP]);
   endproperty
   a_sepRedirect: assert property (p_sepRedirect) else $error("receive input 0 not from lane 1");

   property p_releaseOnRx;
      @(posedge linkClk) disable iff (linkRst) !linkTx [*2] |-> (padOe & LANES_HEX & ~LANES_SER_OUT & ~19'h00010) == 19'h00000;
   endproperty
   a_releaseOnRx: assert property (p_releaseOnRx) else $error("lane driven while receiving");

   property p_chipSelect;
      @(posedge linkClk) disable iff (linkRst) lLegal && linkCe |=> (chipEnableZeroN != chipEnableOneN) && (chipEnableOneN == !$past(lChipOne));
   endproperty
   a_chipSelect: assert property (p_chipSelect) else $error("wrong chip enable");

   property p_codeLegal;
      @(posedge clk) disable iff (rst) (devCfg_q[4:0] == MODE_QUAD1) |-> statusWord[STAT_LEGAL_BIT];
   endproperty
   a_codeLegal: assert property (p_codeLegal) else $error("quad code 0xA not legal");
endmodule

// *** test/mplm_flash_model.sv ***
// Purpose: Behavioural external memory at the far side of the pads
// Assumes: The bench sets the levels that the memory returns
// Notes:   Undriven pads flip every link cycle while deselected
`timescale 1ns/10ps
module mplm_flash_model
   import mplm_pkg::*;
(
   // Link clock
   input wire logic linkClk,
   // Selects and driven pads
   input wire logic chipEnableZeroN,
   input wire logic chipEnableOneN,
   input wire logic [PADS-1:0] padOut,
   input wire logic [PADS-1:0] padOe,
   // Levels returned while selected, and resolved pad levels
   input wire logic [PADS-1:0] respData,
   output logic [PADS-1:0] padIn
);
   logic [PADS-1:0] driveQ = '0;

   // Return data when selected, otherwise a changing pattern
   always @(posedge linkClk)
   begin
      driveQ <= (!chipEnableZeroN || !chipEnableOneN) ? respData : ~driveQ;
   end

   // A pad that the host drives carries the host level
   assign padIn = (padOe & padOut) | (~padOe & driveQ);
endmodule

// *** test/mplm_pad_lane_map_tb_top.sv ***
// Purpose: Self-checking bench for the pad lane mapping
// Assumes: Instance 0, so hex width is present
// Notes:   Link inputs are held levels, changed on clk edges
`timescale 1ns/10ps
module mplm_pad_lane_map_tb_top
   import mplm_pkg::*;
;
   // ***************************************************************
   // Signals
   // ***************************************************************
   logic clk = 0, rst = 1, linkClk = 0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic linkSclk = 0, linkTx = 0, linkCe = 0;
   logic [DATA_LANES-1:0] txData = '0, rxData;
   logic [1:0] txStrobe = '0, rxStrobe;
   logic [PADS-1:0] padIn, padOut, padOe, respData = '0;
   logic chipEnableZeroN, chipEnableOneN;
   int errors = 0, testsRun = 0, cycles = 0;
   logic [4:0] codes [10] = '{MODE_SER0, MODE_SER1, MODE_DUAL0, MODE_DUAL1, MODE_QUAD0, MODE_QUAD1,
                              MODE_OCT0, MODE_OCT1, MODE_HEX0, MODE_HEX1};
   logic [18:0] txOe [5] = '{19'h00101, 19'h00103, 19'h0010F, 19'h003FF, 19'h7FFFF};

   // Register clock, and a link clock of unrelated phase
   always #25 clk = ~clk;
   initial
   begin
      #3.7;
      forever #6 linkClk = ~linkClk;
   end

   mplm_pad_lane_map mplm_pad_lane_map_i (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .linkClk(linkClk), .linkSclk(linkSclk), .linkTx(linkTx),
      .linkCe(linkCe), .txData(txData), .txStrobe(txStrobe), .rxData(rxData), .rxStrobe(rxStrobe),
      .padIn(padIn), .padOut(padOut), .padOe(padOe), .chipEnableZeroN(chipEnableZeroN),
      .chipEnableOneN(chipEnableOneN));

   mplm_flash_model mplm_flash_model_i (.linkClk(linkClk), .chipEnableZeroN(chipEnableZeroN),
      .chipEnableOneN(chipEnableOneN), .padOut(padOut), .padOe(padOe), .respData(respData),
      .padIn(padIn));

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      testsRun++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(s_axi_bresp, er, "bresp");
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      d = s_axi_rdata;
      chk(s_axi_rresp, er, "rresp");
   endtask

   // Program mode and mask, then wait for the link side to settle
   task automatic setCfg(input logic [4:0] m, input logic sep, input logic rl, input logic [18:0] mask);
      logic [31:0] s;
      wr(OFF_DEVCFG, {22'h0, rl, sep, 3'h0, m}, RESP_OKAY);
      wr(OFF_PADOE, {13'h0, mask}, RESP_OKAY);
      repeat (10) @(posedge clk);
      s = 32'h1;
      for (int n = 0; n < 20 && s[STAT_BUSY_BIT]; n++) rd(OFF_STATUS, s, RESP_OKAY);
      chk(s[STAT_BUSY_BIT], 1'b0, "crossing idle");
      repeat (2) @(posedge clk);
   endtask

   // Compare enables, driven levels and chip enables
   task automatic checkPads(input logic [18:0] eoe, input logic ce0, input logic ce1, input logic rl);
      logic [18:0] full;
      repeat (2) @(posedge clk);
      full = {txStrobe[1], txData[15:8], txStrobe[0], linkSclk, txData[7:0]};
      if (rl) full[4] = linkSclk;
      chk(padOe, eoe, "pad enables");
      chk(padOut & eoe, full & eoe, "pad levels");
      chk({chipEnableOneN, chipEnableZeroN}, {ce1, ce0}, "chip enables");
   endtask

   task automatic summarize();
      $display("Counts: %0d checks, %0d mismatches", testsRun, errors);
      if (errors == 0 && testsRun > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic testReset();
      logic [31:0] d;
      repeat (20) @(posedge clk);
      rd(OFF_DEVCFG, d, RESP_OKAY);
      chk(d, DEVCFG_RST, "cfg reset");
      rd(OFF_PADOE, d, RESP_OKAY);
      chk(d, PADOE_RST, "mask reset");
      rd(OFF_STATUS, d, RESP_OKAY);
      chk(d, 32'h4, "status reset");
      checkPads(19'h0, 1, 1, 0);
      $display("test reset done");
   endtask

   // Every width and chip enable, octal before hex, mode before mask
   task automatic testWidths();
      logic [31:0] d;
      linkCe <= 1;
      linkTx <= 1;
      linkSclk <= 1;
      txData <= 16'hA5C3;
      txStrobe <= 2'h2;
      for (int i = 0; i < 10; i++)
      begin
         setCfg(codes[i], 0, 0, 19'h7FFFF);
         rd(OFF_STATUS, d, RESP_OKAY);
         chk(d[STAT_LEGAL_BIT], 1'b1, "mode legal");
         checkPads(txOe[i / 2], i % 2, !(i % 2), 0);
         linkTx <= 0;
         checkPads(i < 2 ? 19'h00101 : 19'h00100, i % 2, !(i % 2), 0);
         linkTx <= 1;
      end
      $display("test widths done");
   endtask

   task automatic testReloc();
      setCfg(MODE_QUAD0, 0, 1, 19'h0011F);
      checkPads(19'h0001F, 0, 1, 1);
      setCfg(MODE_OCT0, 0, 1, 19'h003FF);
      checkPads(19'h003FF, 0, 1, 0);
      setCfg(MODE_QUAD1, 0, 0, 19'h0000F);
      checkPads(19'h0000F, 1, 0, 0);
      $display("test relocation done");
   endtask

   task automatic testSepIo();
      txData <= 16'h0000;
      respData <= 19'h40402;
      setCfg(MODE_SER0, 1, 0, 19'h00103);
      chk(rxData[0], 1'b1, "redirected high");
      chk(rxStrobe, 2'h2, "strobes in");
      chk(rxData[15:8], 8'h01, "upper lanes in");
      respData <= 19'h00000;
      repeat (2) @(posedge clk);
      chk(rxData[0], 1'b0, "redirected low");
      respData <= 19'h00002;
      setCfg(MODE_SER0, 0, 0, 19'h00103);
      chk(rxData[0], 1'b0, "lane zero kept");
      $display("test separate io done");
   endtask

   task automatic testIllegal();
      logic [31:0] d;
      setCfg(5'h03, 0, 0, 19'h7FFFF);
      rd(OFF_STATUS, d, RESP_OKAY);
      chk(d[STAT_LEGAL_BIT], 1'b0, "mode illegal");
      checkPads(19'h0, 1, 1, 0);
      wr(12'h00C, 32'hFFFFFFFF, RESP_SLVERR);
      rd(12'h00C, d, RESP_SLVERR);
      chk(d, 32'h0, "unmapped data");
      $display("test illegal done");
   endtask

   // Cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         summarize();
      end
   end

   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 0;
      testReset();
      testWidths();
      testReloc();
      testSepIo();
      testIllegal();
      summarize();
   end
endmodule
